/* File: common/status_bank_map.svh */
// Purpose: Offsets, field positions and reset values of the status bank
// Assumes: Word-aligned AHB-Lite register map, 32-bit data
// Notes: Printed offsets are not multiples of four; byte address is 4*index
`ifndef STATUS_BANK_MAP_SVH
`define STATUS_BANK_MAP_SVH

// ==========================================================
// Register indexes and address width
`define IDX_SUMMARY 4'h0
`define IDX_MEMFAULT 4'h1
`define IDX_CFGFAULT 4'h2
`define IDX_OPSTATUS 4'h3
`define IDX_CONTROL 4'h4
`define ADDR_BITS 3

// ==========================================================
// Summary word fields
`define SUM_DEVICE_ERR 0
`define SUM_CONFIG_ERR 1
`define SUM_CHANNEL_ERR 2
`define SUM_EXP_COMM_ERR 4
`define SUM_IO_ERR 10
`define SUM_LOWER_IO_ERR 11
`define SUM_IO_ALARM 12
`define SUM_LOWER_IO_ALARM 13
`define SUM_IO_NOTIFY 14

// ==========================================================
// Memory fault word fields
`define MEM_NONVOLATILE 4
`define MEM_CALIBRATION 5
`define MEM_SETTING 6
`define MEM_REGISTRATION 8
`define MEM_MODEL_DATA 9
`define MEM_MODEL_MISMATCH 12

// ==========================================================
// Expansion configuration fault word fields
`define CFG_UNDEFINED_UNIT 0
`define CFG_TOO_MANY 2
`define CFG_UNIT_FAILURE 3
`define CFG_CONN_FAULT 4
`define CFG_MAX_UNITS 4'h9

// ==========================================================
// Operating status and control
`define OP_RAMP_ACTIVE 30
`define CTL_FREEZE 0
`define RESET_STATUS 32'h0000_0000
`define RESET_CONTROL 32'h0000_0000

`endif

/* File: common/status_bank_pkg.sv */
// Purpose: Types for the status bank
// Assumes: Map header gives the numbers
// Notes: Raw fault sources travel as three structs: memory, expansion and other status
`default_nettype none
package status_bank_pkg;

	typedef struct packed {
		logic nonvolatile;
		logic calibration;
		logic setting;
		logic registration;
		logic model_data;
		logic model_mismatch;
	} memory_faults_t;

	typedef struct packed {
		logic undefined_unit;
		logic [3:0] unit_count;
		logic unit_failure;
		logic conn_fault;
	} expansion_faults_t;

	typedef struct packed {
		logic channel_error;
		logic expansion_comm_error;
		logic io_error;
		logic lower_io_error;
		logic io_alarm;
		logic lower_io_alarm;
		logic io_notify;
		logic setpoint_ramp_active;
	} other_status_t;

	typedef struct packed {
		logic [15:0] summary;
		logic [15:0] memfault;
		logic [15:0] cfgfault;
		logic [31:0] opstatus;
	} status_words_t;

endpackage
`default_nettype wire

/* File: src/status_word_builder.sv */
// Purpose: Packs raw fault sources into the status words
// Assumes: Sources are synchronous levels
// Notes: Purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "status_bank_map.svh"

module status_word_builder
(
	input wire status_bank_pkg::memory_faults_t mem,
	input wire status_bank_pkg::expansion_faults_t exp,
	input wire status_bank_pkg::other_status_t oth,
	output status_bank_pkg::status_words_t words
);

	always_comb
	begin
		words = '0;
		words.memfault[`MEM_NONVOLATILE] = mem.nonvolatile;
		words.memfault[`MEM_CALIBRATION] = mem.calibration;
		words.memfault[`MEM_SETTING] = mem.setting;
		words.memfault[`MEM_REGISTRATION] = mem.registration;
		words.memfault[`MEM_MODEL_DATA] = mem.model_data;
		words.memfault[`MEM_MODEL_MISMATCH] = mem.model_mismatch;
		words.cfgfault[`CFG_UNDEFINED_UNIT] = exp.undefined_unit;
		words.cfgfault[`CFG_TOO_MANY] =
			(exp.unit_count > `CFG_MAX_UNITS);
		words.cfgfault[`CFG_UNIT_FAILURE] = exp.unit_failure;
		words.cfgfault[`CFG_CONN_FAULT] = exp.conn_fault;
		words.summary[`SUM_DEVICE_ERR] = |words.memfault;
		words.summary[`SUM_CONFIG_ERR] = |words.cfgfault;
		words.summary[`SUM_CHANNEL_ERR] = oth.channel_error;
		words.summary[`SUM_EXP_COMM_ERR] = oth.expansion_comm_error;
		words.summary[`SUM_IO_ERR] = oth.io_error;
		words.summary[`SUM_LOWER_IO_ERR] = oth.lower_io_error;
		words.summary[`SUM_IO_ALARM] = oth.io_alarm;
		words.summary[`SUM_LOWER_IO_ALARM] = oth.lower_io_alarm;
		words.summary[`SUM_IO_NOTIFY] = oth.io_notify;
		words.opstatus[`OP_RAMP_ACTIVE] = oth.setpoint_ramp_active;
	end

endmodule
`default_nettype wire

/* File: src/error_status_register_bank.sv */
// Purpose: Read-only status word bank on an AHB-Lite slave
// Assumes: Fault sources are synchronous to hclk
// Notes: Zero wait states; writes to status words are ignored
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "status_bank_map.svh"

// Function
// - Operating status bit 30 is high exactly while a setpoint ramp runs.
// - Summary bit 0 flags any memory fault.
// - Summary bit 1 flags any expansion configuration fault.
// - Summary bit 2 flags an error in any control channel.
// - Summary bit 4 flags failed communication with an expansion unit.
// - Summary bit 10 flags a local input/output error.
// - Summary bit 11 flags an error reported by an expansion unit.
// - Summary bit 12 flags an active local input/output alarm.
// - Summary bit 13 flags an alarm in an expansion unit.
// - Summary bit 14 flags a pending input/output notification.
// - Memory fault word holds faults at bits 4, 5, 6, 8, 9 and 12.
// - Configuration fault bit 0 flags an unrecognised expansion unit.
// - Configuration fault bit 2 flags more than nine expansion units.
// - Configuration fault bit 3 flags a failed expansion unit.
// - Configuration fault bit 4 flags a registered unit gone silent.
module error_status_register_bank
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire status_bank_pkg::memory_faults_t mem_faults,
	input wire status_bank_pkg::expansion_faults_t exp_faults,
	input wire status_bank_pkg::other_status_t other_status
);

	status_bank_pkg::status_words_t live;
	logic [15:0] held_summary;
	logic [15:0] held_memfault;
	logic [15:0] held_cfgfault;
	logic [31:0] held_opstatus;
	logic [31:0] control;
	logic wr_pend;
	logic [`ADDR_BITS-1:0] wr_idx;
	logic [31:0] next_rdata;
	logic [`ADDR_BITS-1:0] idx;
	logic access;
	logic rd_take;
	logic wr_take;
	logic freeze;
	logic [31:0] sum_mask;
	logic [31:0] mem_mask;
	logic [31:0] cfg_mask;
	logic [31:0] op_mask;
	logic [31:0] ctl_mask;
	logic [31:0] rd_summary;
	logic [31:0] rd_memfault;
	logic [31:0] rd_cfgfault;
	logic [31:0] rd_opstatus;

	// ==========================================================
	// Status word assembly
	status_word_builder builder
	(
		.mem(mem_faults),
		.exp(exp_faults),
		.oth(other_status),
		.words(live)
	);

	// ==========================================================
	// Snapshot: control bit 0 freezes the words for coherent reads
	assign freeze = control[`CTL_FREEZE];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			held_summary <= 16'h0000;
		else if (!freeze)
			held_summary <= live.summary;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			held_memfault <= 16'h0000;
		else if (!freeze)
			held_memfault <= live.memfault;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			held_cfgfault <= 16'h0000;
		else if (!freeze)
			held_cfgfault <= live.cfgfault;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			held_opstatus <= `RESET_STATUS;
		else if (!freeze)
			held_opstatus <= live.opstatus;
	end

	// ==========================================================
	// AHB-Lite slave
	assign access = hsel && hready && htrans[1];
	assign idx = haddr[`ADDR_BITS+1:2];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign rd_take = access && !hwrite;
	assign wr_take = access && hwrite;

	// ==========================================================
	// Read masks: only named bit positions ever reach the bus
	genvar b;
	generate
		for (b = 0; b < 32; b++)
		begin : g_mask
			assign sum_mask[b] = (b == `SUM_DEVICE_ERR) ||
				(b == `SUM_CONFIG_ERR) ||
				(b == `SUM_CHANNEL_ERR) ||
				(b == `SUM_EXP_COMM_ERR) ||
				(b == `SUM_IO_ERR) ||
				(b == `SUM_LOWER_IO_ERR) ||
				(b == `SUM_IO_ALARM) ||
				(b == `SUM_LOWER_IO_ALARM) ||
				(b == `SUM_IO_NOTIFY);
			assign mem_mask[b] = (b == `MEM_NONVOLATILE) ||
				(b == `MEM_CALIBRATION) ||
				(b == `MEM_SETTING) ||
				(b == `MEM_REGISTRATION) ||
				(b == `MEM_MODEL_DATA) ||
				(b == `MEM_MODEL_MISMATCH);
			assign cfg_mask[b] = (b == `CFG_UNDEFINED_UNIT) ||
				(b == `CFG_TOO_MANY) ||
				(b == `CFG_UNIT_FAILURE) ||
				(b == `CFG_CONN_FAULT);
			assign op_mask[b] = (b == `OP_RAMP_ACTIVE);
			assign ctl_mask[b] = (b == `CTL_FREEZE);
		end
	endgenerate

	// ==========================================================
	// Bus images of the words, unused positions forced to zero
	assign rd_summary = {16'h0000, held_summary} & sum_mask;
	assign rd_memfault = {16'h0000, held_memfault} & mem_mask;
	assign rd_cfgfault = {16'h0000, held_cfgfault} & cfg_mask;
	assign rd_opstatus = held_opstatus & op_mask;

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		unique case ({1'b0, idx})
			`IDX_SUMMARY: next_rdata = rd_summary;
			`IDX_MEMFAULT: next_rdata = rd_memfault;
			`IDX_CFGFAULT: next_rdata = rd_cfgfault;
			`IDX_OPSTATUS: next_rdata = rd_opstatus;
			`IDX_CONTROL: next_rdata = control;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= `RESET_STATUS;
		else if (rd_take)
			hrdata <= next_rdata;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_idx <= '0;
		end
		else
		begin
			wr_pend <= wr_take;
			wr_idx <= idx;
		end
	end

	// Only the control word is writable; status words drop writes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			control <= `RESET_CONTROL;
		else if (wr_pend && ({1'b0, wr_idx} == `IDX_CONTROL))
			control <= hwdata & ctl_mask;
	end

endmodule
`default_nettype wire

/* File: verification/status_expect_pkg.sv */
// Purpose: Expected images of the status words
// Assumes: Fault inputs held steady before each read
// Notes: Index 4 and above read zero while control stays clear
`default_nettype none
package status_expect_pkg;
	function automatic logic [31:0] word(input logic [2:0] i,
		input status_bank_pkg::memory_faults_t m,
		input status_bank_pkg::expansion_faults_t e,
		input status_bank_pkg::other_status_t o);
		logic [15:0] mw;
		logic [15:0] cw;
		mw = {3'h0, m.model_mismatch, 2'h0, m.model_data, m.registration,
			1'h0, m.setting, m.calibration, m.nonvolatile, 4'h0};
		cw = {11'h0, e.conn_fault, e.unit_failure, e.unit_count > 4'h9,
			1'h0, e.undefined_unit};
		case (i)
			3'h0: word = {17'h0, o.io_notify, o.lower_io_alarm, o.io_alarm,
				o.lower_io_error, o.io_error, 5'h0, o.expansion_comm_error,
				1'h0, o.channel_error, |cw, |mw};
			3'h1: word = {16'h0, mw};
			3'h2: word = {16'h0, cw};
			3'h3: word = {1'h0, o.setpoint_ramp_active, 30'h0};
			default: word = 32'h0;
		endcase
	endfunction
endpackage
`default_nettype wire

/* File: verification/status_bank_assertions.sv */
// Purpose: Checker of read timing and word images
// Assumes: Control writes are seen on the bus, so freeze can be mirrored
// Notes: Snapshot is two edges behind the data phase
`timescale 1ns/10ps
`default_nettype none
module status_bank_checker
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire status_bank_pkg::memory_faults_t mem_faults,
	input wire status_bank_pkg::expansion_faults_t exp_faults,
	input wire status_bank_pkg::other_status_t other_status
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic ctl_wr;
	logic frozen;
	// Mirror of the freeze bit, from writes seen on the bus
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctl_wr <= 1'b0;
			frozen <= 1'b0;
		end
		else
		begin
			ctl_wr <= hsel && hready && htrans[1] && hwrite &&
				haddr[4:2] == 3'h4;
			if (ctl_wr)
				frozen <= hwdata[0];
		end
	end
	sequence rd_taken;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	property word_ok(logic [2:0] i);
		rd_taken ##0 haddr[4:2] == i ##0 !$past(frozen) |=>
			hrdata == status_expect_pkg::word(i, $past(mem_faults, 2),
			$past(exp_faults, 2), $past(other_status, 2));
	endproperty
	a_summary_word: assert property (word_ok(3'h0))
		else $error("summary word wrong");
	a_memory_word: assert property (word_ok(3'h1))
		else $error("memory fault word wrong");
	a_config_word: assert property (word_ok(3'h2))
		else $error("config fault word wrong");
	a_ramp_word: assert property (word_ok(3'h3))
		else $error("ramp word wrong");
	a_unmapped_zero: assert property (
		rd_taken ##0 haddr[4:2] > 3'h4 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_data_holds: assert property (
		!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
		else $error("read data moved");
	a_always_ready: assert property (hreadyout)
		else $error("wait state inserted");
	a_resp_okay: assert property (!hresp)
		else $error("error response");
endmodule
bind error_status_register_bank status_bank_checker chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .mem_faults(mem_faults),
	.exp_faults(exp_faults), .other_status(other_status));
`default_nettype wire

/* File: verification/ahb_host_model.sv */
// Purpose: Host reaching the status words over AHB-Lite
// Assumes: Single whole-word transfers
// Notes: Released write data is inverted so stale values never match
`timescale 1ns/10ps
`default_nettype none
module ahb_host_model
(
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel = 1'b0,
	output logic [31:0] haddr = 32'h0,
	output logic [1:0] htrans = 2'h0,
	output logic hwrite = 1'b0,
	output logic [2:0] hsize = 3'h2,
	output logic [31:0] hwdata = 32'h0
);
	task xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		q = hrdata;
		hwdata <= ~d;
	endtask
endmodule
`default_nettype wire

/* File: verification/error_status_register_bank_bench.sv */
// Purpose: Random fault patterns read back through the bus
// Assumes: Freeze bit in control is set once, after the random patterns
// Notes: Every status write is expected to be ignored
`timescale 1ns/10ps
`default_nettype none
module error_status_register_bank_bench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] q;
	logic [31:0] r;
	logic [31:0] want;
	status_bank_pkg::memory_faults_t fm;
	status_bank_pkg::expansion_faults_t fe;
	status_bank_pkg::other_status_t fo;
	status_bank_pkg::memory_faults_t mem_faults = '0;
	status_bank_pkg::expansion_faults_t exp_faults = '0;
	status_bank_pkg::other_status_t other_status = '0;
	integer seed = 28408;
	integer bad_count = 0;
	integer total_checks = 0;
	always #5 hclk = ~hclk;
	error_status_register_bank u_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.mem_faults(mem_faults), .exp_faults(exp_faults),
		.other_status(other_status));
	ahb_host_model u_host (.hclk(hclk), .hready(hreadyout),
		.hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	task check(input logic [31:0] seen, input logic [31:0] want);
		total_checks = total_checks + 1;
		if (seen !== want)
		begin
			bad_count = bad_count + 1;
			$display("BAD %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task finish_test;
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		#100000;
		bad_count = bad_count + 1;
		finish_test;
	end
	initial
	begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		for (int n = 0; n < 48; n++)
		begin
			@(posedge hclk);
			r = $random(seed);
			mem_faults <= (n < 3) ? 6'h0 : r[5:0];
			exp_faults <= (n < 3) ? 7'h24 + 7'(n * 4) : r[12:6];
			other_status <= (n < 3) ? 8'h0 : r[20:13];
			for (int i = 0; i < 8; i++)
			begin
				if (i != 4)
					u_host.xfer(32'(i * 4), 1'b1, $random(seed), q);
				u_host.xfer(32'(i * 4), 1'b0, 32'h0, q);
				want = status_expect_pkg::word(3'(i), mem_faults,
					exp_faults, other_status);
				check(q, want);
			end
		end
		// Freeze the snapshot, then move every source
		u_host.xfer(32'h0000_0010, 1'b1, 32'hFFFF_FFFF, q);
		fm = mem_faults;
		fe = exp_faults;
		fo = other_status;
		mem_faults <= ~fm;
		exp_faults <= ~fe;
		other_status <= ~fo;
		u_host.xfer(32'h0000_0010, 1'b0, 32'h0, q);
		check(q, 32'h0000_0001);
		for (int i = 0; i < 4; i++)
		begin
			u_host.xfer(32'(i * 4), 1'b0, 32'h0, q);
			want = status_expect_pkg::word(3'(i), fm, fe, fo);
			check(q, want);
		end
		// Release: the words follow the moved sources again
		u_host.xfer(32'h0000_0010, 1'b1, 32'h0, q);
		for (int i = 0; i < 4; i++)
		begin
			u_host.xfer(32'(i * 4), 1'b0, 32'h0, q);
			want = status_expect_pkg::word(3'(i), mem_faults,
				exp_faults, other_status);
			check(q, want);
		end
		finish_test;
	end
endmodule
`default_nettype wire
